// file: logic/cap_bank.sv
// Capability configuration register bank with decoded advertised values.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module cap_bank
    import cap_bank_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [11:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    input wire logic root_port_in,
    input wire logic gen2_rate_in,
    input wire logic conv_reset_in,
    input wire logic aux_pm_en_in,
    input wire logic [9:0] err_event_in,
    output logic prefix_support_out,
    output logic obff_support_out,
    output logic cpl_dis_support_out,
    output logic [3:0] cpl_range_mask_out,
    output logic cpl_range_reserved_out,
    output logic deemph_active_out,
    output logic deemph_3p5db_out,
    output logic [4:0] wake_states_out,
    output logic state_two_advert_out,
    output logic state_one_advert_out,
    output logic [8:0] aux_current_ma_out,
    output logic self_powered_out,
    output logic init_seq_out,
    output logic [14:0] power_mw_out,
    output logic power_unknown_out,
    output logic [1:0] power_state_out,
    output logic power_consumed_out,
    output logic power_dissipated_out,
    output logic power_common_out,
    output logic power_sel_reserved_out,
    output logic aux_pm_en_out,
    output logic routing_present_out,
    output logic [9:0] err_enable_out,
    output logic [9:0] err_report_out,
    output logic ecrc_capable_out,
    output logic [3:0] err_version_out
);

    // ******************************************************************
    // Register file
    // ******************************************************************
    logic [31:0] regs_r [NUM_REGS];
    logic [31:0] regs_nxt [NUM_REGS];
    logic [31:0] rd_data_r;
    logic [31:0] rd_data_nxt;
    logic aux_pm_en_r;
    logic aux_pm_en_nxt;
    logic [9:0] err_report_r;
    logic [9:0] err_report_nxt;
    logic aux_sticky;

    always_comb begin
        rd_data_nxt = 32'h00000000;
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
            if (wr_in && addr_in == REG_OFS[i]) begin
                regs_nxt[i] = wr_data_in & REG_MASK[i];
            end
            if (rd_in && addr_in == REG_OFS[i]) begin
                rd_data_nxt = regs_r[i] & REG_MASK[i];
            end
        end
    end

    // ******************************************************************
    // Aux power enable and error gating
    // ******************************************************************
    // Sticky when aux power is needed and either D3cold wake or a current.
    assign aux_sticky = regs_r[IDX_POWER_MGMT_AUX_SUPPLY][AUX_REQ_BIT] &&
        (regs_r[IDX_POWER_MGMT_CAPABILITIES][WAKE_LSB + WAKE_D3COLD] ||
         regs_r[IDX_POWER_MGMT_CAPABILITIES][AUX_CUR_LSB +: 3] != 3'h0);

    always_comb begin
        aux_pm_en_nxt = aux_pm_en_in;
        if (conv_reset_in) begin
            aux_pm_en_nxt = aux_sticky && aux_pm_en_r;
        end
        err_report_nxt = err_event_in & err_enable_out;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= REG_RESET[i];
            end
            rd_data_r <= 32'h00000000;
            aux_pm_en_r <= 1'b0;
            err_report_r <= 10'h000;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
            rd_data_r <= rd_data_nxt;
            aux_pm_en_r <= aux_pm_en_nxt;
            err_report_r <= err_report_nxt;
        end
    end

    // ******************************************************************
    // Decoded advertisements
    // ******************************************************************
    logic [3:0] range_code;
    logic [1:0] scale_code;
    logic [3:0] sel_code;
    logic [7:0] data_byte;

    assign range_code = regs_r[IDX_DEV_CAP2][CPL_RANGE_LSB +: 4];
    assign scale_code = regs_r[IDX_PM_CSR][SCALE_LSB +: 2];
    assign sel_code = regs_r[IDX_PM_CSR][SELECT_LSB +: 4];
    assign data_byte = regs_r[IDX_PM_CSR][DATA_LSB +: 8];

    assign rd_data_out = rd_data_r;
    assign prefix_support_out = regs_r[IDX_DEV_CAP2][PREFIX_BIT];
    assign obff_support_out = regs_r[IDX_DEV_CAP2][OBFF_BIT];
    assign cpl_dis_support_out = regs_r[IDX_DEV_CAP2][CPL_DIS_BIT];

    // Mask bit 0 is range A up to bit 3 for range D.
    always_comb begin
        cpl_range_reserved_out = 1'b0;
        unique case (range_code)
            4'h0: cpl_range_mask_out = 4'h0;
            4'h1: cpl_range_mask_out = 4'h1;
            4'h2: cpl_range_mask_out = 4'h2;
            4'h3: cpl_range_mask_out = 4'h3;
            4'h4: cpl_range_mask_out = 4'h6;
            4'h5: cpl_range_mask_out = 4'h7;
            4'h6: cpl_range_mask_out = 4'hE;
            4'h7: cpl_range_mask_out = 4'hF;
            default: begin
                cpl_range_mask_out = 4'h0;
                cpl_range_reserved_out = 1'b1;
            end
        endcase
    end

    // The select bit only matters for a root port at the second rate.
    assign deemph_active_out = root_port_in && gen2_rate_in;
    assign deemph_3p5db_out = deemph_active_out &&
        regs_r[IDX_LINK_CTL2][DEEMPH_BIT];
    assign wake_states_out = regs_r[IDX_POWER_MGMT_CAPABILITIES][WAKE_LSB +: 5];
    assign state_two_advert_out = regs_r[IDX_POWER_MGMT_CAPABILITIES][STATE_TWO_BIT];
    assign state_one_advert_out = regs_r[IDX_POWER_MGMT_CAPABILITIES][STATE_ONE_BIT];
    assign init_seq_out = regs_r[IDX_POWER_MGMT_CAPABILITIES][INIT_SEQ_BIT];

    always_comb begin
        unique case (regs_r[IDX_POWER_MGMT_CAPABILITIES][AUX_CUR_LSB +: 3])
            3'h0: aux_current_ma_out = 9'h000;
            3'h1: aux_current_ma_out = 9'h037;
            3'h2: aux_current_ma_out = 9'h064;
            3'h3: aux_current_ma_out = 9'h0A0;
            3'h4: aux_current_ma_out = 9'h0DC;
            3'h5: aux_current_ma_out = 9'h10E;
            3'h6: aux_current_ma_out = 9'h140;
            3'h7: aux_current_ma_out = 9'h177;
        endcase
    end
    assign self_powered_out =
        regs_r[IDX_POWER_MGMT_CAPABILITIES][AUX_CUR_LSB +: 3] == 3'h0;

    // Power is reported in milliwatts so all scales stay integer.
    always_comb begin
        power_unknown_out = 1'b0;
        unique case (scale_code)
            2'h0: begin
                power_mw_out = 15'h0000;
                power_unknown_out = 1'b1;
            end
            // Widen before the product so the top bits are not lost.
            2'h1: power_mw_out = 15'(data_byte) * 15'd100;
            2'h2: power_mw_out = 15'(data_byte) * 15'd10;
            2'h3: power_mw_out = 15'(data_byte);
        endcase
    end

    assign power_state_out = sel_code[1:0];
    assign power_consumed_out = sel_code[3:2] == 2'h0;
    assign power_dissipated_out = sel_code[3:2] == 2'h1;
    assign power_common_out = sel_code == SEL_COMMON;
    assign power_sel_reserved_out = sel_code > SEL_COMMON;

    assign aux_pm_en_out = aux_pm_en_r;
    assign routing_present_out =
        !regs_r[IDX_ROUTING][ROUTING_DIS_BIT];
    assign err_enable_out = regs_r[IDX_ERR][ERR_EN_LSB +: 10];
    assign err_report_out = err_report_r;
    assign ecrc_capable_out = regs_r[IDX_ERR][ECRC_BIT];
    assign err_version_out = regs_r[IDX_ERR][ERR_VER_BIT] ?
        ERR_VER_TWO : ERR_VER_ONE;

endmodule

// file: shared/cap_bank_pkg.sv
// Package with the register map, field positions and reset values.
package cap_bank_pkg;

    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam int NUM_REGS = 7;
    localparam int ADDR_W = 12;
    localparam logic [11:0] DEVICE_CAPABILITIES_TWO_OFS = 12'h098;
    localparam logic [11:0] LINK_CONTROL_TWO_OFS = 12'h0A0;
    localparam logic [11:0] POWER_MGMT_CAPABILITIES_OFS = 12'h0C0;
    localparam logic [11:0] POWER_MGMT_CONTROL_STATUS_OFS = 12'h0C4;
    localparam logic [11:0] POWER_MGMT_AUX_SUPPLY_OFS = 12'h0C8;
    localparam logic [11:0] ROUTING_ID_CAPABILITY_OFS = 12'h0E0;
    localparam logic [11:0] ERROR_REPORTING_CAPABILITY_OFS = 12'h100;

    localparam logic [11:0] REG_OFS [NUM_REGS] = '{
        DEVICE_CAPABILITIES_TWO_OFS, LINK_CONTROL_TWO_OFS,
        POWER_MGMT_CAPABILITIES_OFS, POWER_MGMT_CONTROL_STATUS_OFS,
        POWER_MGMT_AUX_SUPPLY_OFS, ROUTING_ID_CAPABILITY_OFS,
        ERROR_REPORTING_CAPABILITY_OFS};

    // Writable bits; everything else is reserved and reads zero.
    localparam logic [31:0] REG_MASK [NUM_REGS] = '{
        32'h0024001F, 32'h00000040, 32'h0000FFEF, 32'hFFC07E00,
        32'h00000001, 32'h00000001, 32'hFFC00003};

    localparam logic [31:0] REG_RESET [NUM_REGS] = '{
        32'h00000010, 32'h00000000, 32'h0000FE03, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h01000002};

    localparam int IDX_DEV_CAP2 = 0;
    localparam int IDX_LINK_CTL2 = 1;
    localparam int IDX_POWER_MGMT_CAPABILITIES = 2;
    localparam int IDX_PM_CSR = 3;
    localparam int IDX_POWER_MGMT_AUX_SUPPLY = 4;
    localparam int IDX_ROUTING = 5;
    localparam int IDX_ERR = 6;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int PREFIX_BIT = 21;
    localparam int OBFF_BIT = 18;
    localparam int CPL_DIS_BIT = 4;
    localparam int CPL_RANGE_LSB = 0;
    localparam int DEEMPH_BIT = 6;
    localparam int WAKE_LSB = 11;
    localparam int STATE_TWO_BIT = 10;
    localparam int STATE_ONE_BIT = 9;
    localparam int AUX_CUR_LSB = 6;
    localparam int INIT_SEQ_BIT = 5;
    localparam int WAKE_CLK_BIT = 3;
    localparam int PM_VER_LSB = 0;
    localparam int DATA_LSB = 24;
    localparam int SCALE_LSB = 13;
    localparam int SELECT_LSB = 9;
    localparam int AUX_REQ_BIT = 0;
    localparam int ROUTING_DIS_BIT = 0;
    localparam int ERR_EN_LSB = 22;
    localparam int ECRC_BIT = 1;
    localparam int ERR_VER_BIT = 0;
    localparam int WAKE_D3COLD = 4;

    localparam logic [3:0] ERR_VER_ONE = 4'h1;
    localparam logic [3:0] ERR_VER_TWO = 4'h2;
    localparam logic [3:0] SEL_COMMON = 4'h8;

endpackage

// file: testbench/cap_bank_properties.sv
// Port-level assertions for the capability configuration bank.
`timescale 1ns/1ps
// ******************************************************************
// Checker
// ******************************************************************
// Ports are grouped by type to keep the checker short.
module cap_bank_properties (
    input wire logic mclk_in, rst_in, rd_in, root_port_in, gen2_rate_in,
    input wire logic conv_reset_in, aux_pm_en_in, aux_pm_en_out,
    input wire logic deemph_3p5db_out, cpl_range_reserved_out,
    input wire logic power_unknown_out, self_powered_out,
    input wire logic [31:0] rd_data_out,
    input wire logic [9:0] err_event_in, err_enable_out, err_report_out,
    input wire logic [3:0] cpl_range_mask_out,
    input wire logic [14:0] power_mw_out,
    input wire logic [8:0] aux_current_ma_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    rd_quiet_a: assert property (
        !$past(rd_in) |-> rd_data_out == 32'h0)
        else $error("read data outside the answer cycle");
    err_gate_a: assert property (
        !$past(rst_in) |-> err_report_out == $past(err_event_in & err_enable_out))
        else $error("error report not gated by its enable");
    deemph_gate_a: assert property (
        deemph_3p5db_out |-> root_port_in && gen2_rate_in)
        else $error("de-emphasis select outside root port gen2");
    range_rsv_a: assert property (
        cpl_range_reserved_out |-> cpl_range_mask_out == 4'h0)
        else $error("reserved range code advertises ranges");
    scale_unknown_a: assert property (
        power_unknown_out |-> power_mw_out == 15'h0)
        else $error("unknown scale gives nonzero power");
    self_power_a: assert property (
        self_powered_out == (aux_current_ma_out == 9'h0))
        else $error("self powered flag disagrees with current");
    aux_follow_a: assert property (
        !$past(rst_in) && !$past(conv_reset_in)
        |-> aux_pm_en_out == $past(aux_pm_en_in))
        else $error("aux enable does not follow its input");
    aux_hold_a: assert property (
        $past(conv_reset_in) && !$past(aux_pm_en_out) |-> !aux_pm_en_out)
        else $error("aux enable set during conventional reset");
endmodule

// file: testbench/host_cfg_model.sv
// Host-side model: legal words the configuring software writes.
`timescale 1ns/1ps
// ******************************************************************
// Host words
// ******************************************************************
module host_cfg_model #(parameter bit SRIOV_ON = 1'h1) (
    output logic [31:0] dev_word_out,
    output logic [31:0] pwr_word_out,
    output logic [31:0] rt_word_out,
    output logic [31:0] err_word_out
);
    // The attached design offers timeout disable and ranges A and B.
    assign dev_word_out = 32'h00000013;
    assign pwr_word_out = 32'h0000FE03;
    assign rt_word_out = {31'h0, ~SRIOV_ON};
    // The core cannot raise these errors, so their enables stay clear.
    assign err_word_out = 32'hD3C00003;
endmodule

// file: testbench/cap_bank_tb_top.sv
// Self-checking testbench for the capability configuration bank.
`timescale 1ns/1ps
// ******************************************************************
// Bench
// ******************************************************************
module cap_bank_tb_top;
    import cap_bank_pkg::*;
    logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, root_port_in = 0;
    logic gen2_rate_in = 0, conv_reset_in = 0, aux_pm_en_in = 0;
    logic [11:0] addr_in = 12'h000;
    logic [31:0] wr_data_in = 32'h0, rd_data_out, w_dc, w_pw, w_rt, w_er;
    logic [9:0] err_event_in = 10'h000, rep;
    logic [3:0] msk, ver;
    logic [8:0] ma;
    logic [14:0] mw;
    logic [1:0] pst;
    logic [4:0] wk;
    logic da;
    logic pf, ob, cd, rr, dp, s2, s1, sp, ini, pu, pc, pd, pcm, ps, ae, rp, ec;
    wire [11:0] flg = {pf, ob, cd, s2, s1, ini, ec, rp, ver};
    int failures = 0, checks_done = 0;
    localparam logic [3:0] RNG [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7,
        4'hE, 4'hF};
    localparam logic [8:0] MA [8] = '{9'h000, 9'h037, 9'h064, 9'h0A0,
        9'h0DC, 9'h10E, 9'h140, 9'h177};
    localparam logic [14:0] MW [4] = '{15'h0, 15'h4E20, 15'h07D0, 15'h00C8};
    always #4 mclk_in = ~mclk_in;
    cap_bank dut (.mclk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
        .rd_data_out, .root_port_in, .gen2_rate_in, .conv_reset_in,
        .aux_pm_en_in, .err_event_in, .prefix_support_out(pf),
        .obff_support_out(ob), .cpl_dis_support_out(cd),
        .cpl_range_mask_out(msk), .cpl_range_reserved_out(rr),
        .deemph_active_out(da), .deemph_3p5db_out(dp), .wake_states_out(wk),
        .state_two_advert_out(s2), .state_one_advert_out(s1),
        .aux_current_ma_out(ma), .self_powered_out(sp), .init_seq_out(ini),
        .power_mw_out(mw), .power_unknown_out(pu), .power_state_out(pst),
        .power_consumed_out(pc), .power_dissipated_out(pd),
        .power_common_out(pcm), .power_sel_reserved_out(ps),
        .aux_pm_en_out(ae), .routing_present_out(rp), .err_enable_out(),
        .err_report_out(rep), .ecrc_capable_out(ec), .err_version_out(ver));
    host_cfg_model host (.dev_word_out(w_dc), .pwr_word_out(w_pw),
        .rt_word_out(w_rt), .err_word_out(w_er));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Every access starts on a rising edge and returns at the falling
    // edge, so checks that follow never race the register update.
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge mclk_in);
        wr_in <= 1'h1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'h0;
        @(negedge mclk_in);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        @(posedge mclk_in);
        rd_in <= 1'h1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'h0;
        @(negedge mclk_in);
        chk("rd_data_out", rd_data_out, e);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'h0;
        @(negedge mclk_in);
        chk("flags", flg, 12'h3B1);
        chk("wake_states", wk, 5'h1F);
        for (int i = 0; i < NUM_REGS; i++)
            rd(REG_OFS[i], REG_RESET[i]);
        @(posedge mclk_in);
        err_event_in <= 10'h3FF;
        aux_pm_en_in <= 1'h1;
        @(posedge mclk_in);
        @(negedge mclk_in);
        chk("err_report_out", rep, 10'h004);
        chk("aux_follow", ae, 1'h1);
        @(posedge mclk_in);
        conv_reset_in <= 1'h1;
        err_event_in <= 10'h000;
        @(posedge mclk_in);
        @(negedge mclk_in);
        chk("aux_cleared", ae, 1'h0);
        @(posedge mclk_in);
        conv_reset_in <= 1'h0;
        wr(12'h0C8, 32'h1);
        @(posedge mclk_in);
        conv_reset_in <= 1'h1;
        aux_pm_en_in <= 1'h0;
        @(posedge mclk_in);
        @(negedge mclk_in);
        chk("aux_sticky", ae, 1'h1);
        @(posedge mclk_in);
        conv_reset_in <= 1'h0;
        $display("reset and aux test done");
        for (int i = 0; i < NUM_REGS; i++)
            wr(REG_OFS[i], 32'hFFFFFFFF);
        wr(12'h0A4, 32'hFFFFFFFF);
        for (int i = 0; i < NUM_REGS; i++)
            rd(REG_OFS[i], REG_MASK[i]);
        rd(12'h0A4, 32'h0);
        chk("flags", flg, 12'hFE2);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            {root_port_in, gen2_rate_in} <= i[1:0];
            @(negedge mclk_in);
            chk("deemph", dp, i == 3);
            chk("deemph_active", da, i == 3);
        end
        $display("mask test done");
        for (int i = 0; i < 16; i++) begin
            wr(12'h098, i);
            chk("rng", {rr, msk}, i > 7 ? 5'h10 : {1'h0, RNG[i % 8]});
        end
        for (int i = 0; i < 8; i++) begin
            wr(12'h0C0, i << 6);
            chk("aux_ma", {sp, ma}, {i == 0, MA[i]});
        end
        for (int i = 0; i < 16; i++) begin
            wr(12'h0C4, {8'hC8, 9'h000, i[1:0], i[3:0], 9'h000});
            chk("pwr", {pu, mw}, {i % 4 == 0, MW[i % 4]});
            chk("sel", {pc, pd, pcm, ps, pst},
                {i < 4, i / 4 == 1, i == 8, i > 8, i[1:0]});
        end
        $display("decode test done");
        wr(12'h098, w_dc);
        rd(12'h098, 32'h00000013);
        wr(12'h0C0, w_pw);
        rd(12'h0C0, 32'h0000FE03);
        wr(12'h0E0, w_rt);
        chk("routing", rp, 1'h1);
        wr(12'h100, w_er);
        rd(12'h100, 32'hD3C00003);
        $display("host word test done");
        complete_run();
    end
endmodule

bind cap_bank cap_bank_properties chk_i (.mclk_in, .rst_in, .rd_in,
    .root_port_in, .gen2_rate_in, .conv_reset_in, .aux_pm_en_in,
    .aux_pm_en_out, .deemph_3p5db_out, .cpl_range_reserved_out,
    .power_unknown_out, .self_powered_out, .rd_data_out, .err_event_in,
    .err_enable_out, .err_report_out, .cpl_range_mask_out, .power_mw_out,
    .aux_current_ma_out);
